//--- verilog/lpta_pkg.sv
`default_nettype none
package lpta_pkg;
  // Timing
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned LIGHT_IT_BASE_MS = 50;
  localparam int unsigned LIGHT_IT_BASE_CYC = (CLK_HZ / 1000) * LIGHT_IT_BASE_MS;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_LIGHT_CONF = 6'h00;
  localparam logic [5:0] IDX_LIGHT_UPPER = 6'h01;
  localparam logic [5:0] IDX_LIGHT_LOWER = 6'h02;
  localparam logic [5:0] IDX_PROX_CONF = 6'h03;
  localparam logic [5:0] IDX_PROX_THR = 6'h06;
  localparam logic [5:0] IDX_PROX_RESULT = 6'h08;
  localparam logic [5:0] IDX_LIGHT_RESULT = 6'h09;
  localparam logic [5:0] IDX_FLAG = 6'h0D;
  localparam logic [5:0] IDX_ID = 6'h0E;

  // Light configuration fields
  localparam int LC_IT_POS = 6;
  localparam int LC_PERS_POS = 2;
  localparam int LC_EN_POS = 1;
  // Proximity configuration fields
  localparam int PC_PERS_POS = 0;
  localparam int PC_EN_POS = 2;
  localparam int PC_MODE_POS = 3;
  // Proximity threshold word: lower in low byte, upper in high byte
  localparam int PT_UPPER_POS = 8;
  // Flag byte sits in the high byte of its word
  localparam int FLAG_BYTE_POS = 8;
  localparam int FLAG_PROX_SAT = 7;
  localparam int FLAG_SUN = 6;
  localparam int FLAG_LIGHT_BELOW = 5;
  localparam int FLAG_LIGHT_ABOVE = 4;
  localparam int FLAG_PROX_NEAR = 1;
  localparam int FLAG_PROX_FAR = 0;
  localparam logic [7:0] FLAG_LIGHT_MASK = 8'h30;
  localparam logic [7:0] FLAG_PROX_MASK = 8'hC3;

  // Reset values
  localparam logic [7:0] LIGHT_CONF_RST = 8'h00;
  localparam logic [15:0] LIGHT_UPPER_RST = 16'hFFFF;
  localparam logic [15:0] LIGHT_LOWER_RST = 16'h0000;
  localparam logic [7:0] PROX_CONF_RST = 8'h00;
  localparam logic [7:0] PROX_UPPER_RST = 8'hFF;
  localparam logic [7:0] PROX_LOWER_RST = 8'h00;
  // Arbitrary identification value
  localparam logic [15:0] ID_RST = 16'h00A5;

  typedef struct packed {
    logic valid;
    logic saturated;
    logic sunlight;
    logic [7:0] data;
  } lpta_prox_in_s;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic [7:0] light_conf;
    logic [15:0] light_upper;
    logic [15:0] light_lower;
    logic [15:0] light_result;
    logic [7:0] prox_conf;
    logic [7:0] prox_upper;
    logic [7:0] prox_lower;
    logic [7:0] prox_result;
    logic [7:0] flags;
    logic [3:0] light_cnt;
    logic [2:0] prox_hi_cnt;
    logic [2:0] prox_lo_cnt;
    logic prox_near;
    logic alert_n;
    logic [31:0] timer;
    logic light_tick;
  } lpta_state_s;
endpackage
`default_nettype wire

//--- verilog/lpta_top.sv
// The Wishbone slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module lpta_top #(
  parameter int unsigned LIGHT_BASE_CYCLES = lpta_pkg::LIGHT_IT_BASE_CYC
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic [15:0] LIGHT_DATA,
  output logic LIGHT_TICK,
  input wire lpta_pkg::lpta_prox_in_s PROX_IN,
  output logic ALERT_N
);

  lpta_pkg::lpta_state_s st_reg;
  lpta_pkg::lpta_state_s st_next;

  logic [5:0] idx;
  logic take;
  logic wr;
  logic rd_done;
  logic [31:0] period;
  logic tick_c;
  logic [1:0] light_it;
  logic [3:0] light_need;
  logic light_above;
  logic light_below;
  logic light_en;
  logic [2:0] prox_need;
  logic prox_above;
  logic prox_below;
  logic prox_en;
  logic prox_mode;
  logic [7:0] flag_set;
  logic [7:0] flag_mask;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [1:0] sel,
                                          input logic [15:0] data);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = data[7:0];
    end
    if (sel[1]) begin
      r[15:8] = data[15:8];
    end
    return r;
  endfunction

  assign idx = WB_ADR_I[7:2];
  assign take = WB_CYC_I & WB_STB_I & ~st_reg.ack;
  // Writes and read side effects land on the edge where the master sees ack
  assign wr = WB_CYC_I & WB_STB_I & WB_WE_I & st_reg.ack;
  assign rd_done = WB_CYC_I & WB_STB_I & ~WB_WE_I & st_reg.ack;

  assign light_it = st_reg.light_conf[lpta_pkg::LC_IT_POS +: 2];
  assign light_need = 4'(4'h1 << st_reg.light_conf[lpta_pkg::LC_PERS_POS +: 2]);
  assign light_en = st_reg.light_conf[lpta_pkg::LC_EN_POS];
  assign prox_need = 3'(st_reg.prox_conf[lpta_pkg::PC_PERS_POS +: 2]) + 3'h1;
  assign prox_en = st_reg.prox_conf[lpta_pkg::PC_EN_POS];
  assign prox_mode = st_reg.prox_conf[lpta_pkg::PC_MODE_POS];
  assign flag_mask = (light_en ? lpta_pkg::FLAG_LIGHT_MASK : 8'h00) |
                     (prox_en ? lpta_pkg::FLAG_PROX_MASK : 8'h00);

  // Refresh period doubles with each integration step
  assign period = 32'(LIGHT_BASE_CYCLES) << light_it;
  assign tick_c = (st_reg.timer >= period - 32'h1);

  assign light_above = LIGHT_DATA > st_reg.light_upper;
  assign light_below = LIGHT_DATA < st_reg.light_lower;
  assign prox_above = PROX_IN.data > st_reg.prox_upper;
  assign prox_below = PROX_IN.data < st_reg.prox_lower;

  always_comb begin
    st_next = st_reg;
    flag_set = 8'h00;

    // Bus slave: ack one cycle after the request, dropped the cycle after
    st_next.ack = take;
    if (take) begin
      unique case (idx)
        lpta_pkg::IDX_LIGHT_CONF: st_next.dat = {24'h000000, st_reg.light_conf};
        lpta_pkg::IDX_LIGHT_UPPER: st_next.dat = {16'h0000, st_reg.light_upper};
        lpta_pkg::IDX_LIGHT_LOWER: st_next.dat = {16'h0000, st_reg.light_lower};
        lpta_pkg::IDX_PROX_CONF: st_next.dat = {24'h000000, st_reg.prox_conf};
        lpta_pkg::IDX_PROX_THR: st_next.dat = {16'h0000, st_reg.prox_upper, st_reg.prox_lower};
        lpta_pkg::IDX_PROX_RESULT: st_next.dat = {24'h000000, st_reg.prox_result};
        lpta_pkg::IDX_LIGHT_RESULT: st_next.dat = {16'h0000, st_reg.light_result};
        lpta_pkg::IDX_FLAG: st_next.dat = {16'h0000, st_reg.flags, 8'h00};
        lpta_pkg::IDX_ID: st_next.dat = {16'h0000, lpta_pkg::ID_RST};
        default: st_next.dat = 32'h00000000;
      endcase
    end

    // Register writes are never blocked by the alert state
    if (wr) begin
      unique case (idx)
        lpta_pkg::IDX_LIGHT_CONF: begin
          if (WB_SEL_I[0]) begin
            st_next.light_conf = WB_DAT_I[7:0];
          end
        end
        lpta_pkg::IDX_LIGHT_UPPER: st_next.light_upper = merge16(st_reg.light_upper, WB_SEL_I[1:0], WB_DAT_I[15:0]);
        lpta_pkg::IDX_LIGHT_LOWER: st_next.light_lower = merge16(st_reg.light_lower, WB_SEL_I[1:0], WB_DAT_I[15:0]);
        lpta_pkg::IDX_PROX_CONF: begin
          if (WB_SEL_I[0]) begin
            st_next.prox_conf = WB_DAT_I[7:0];
          end
        end
        lpta_pkg::IDX_PROX_THR: begin
          if (WB_SEL_I[0]) begin
            st_next.prox_lower = WB_DAT_I[7:0];
          end
          if (WB_SEL_I[1]) begin
            st_next.prox_upper = WB_DAT_I[lpta_pkg::PT_UPPER_POS +: 8];
          end
        end
        default: begin
        end
      endcase
    end

    // Integration timer; after a field change, a period already past its new length ends at once
    st_next.light_tick = tick_c;
    st_next.timer = tick_c ? 32'h00000000 : st_reg.timer + 32'h1;
    if (tick_c) begin
      st_next.light_result = LIGHT_DATA;
      if (light_above | light_below) begin
        if (st_reg.light_cnt < light_need) begin
          st_next.light_cnt = st_reg.light_cnt + 4'h1;
        end
        if (st_reg.light_cnt + 4'h1 == light_need) begin
          flag_set[lpta_pkg::FLAG_LIGHT_ABOVE] = light_en & light_above;
          flag_set[lpta_pkg::FLAG_LIGHT_BELOW] = light_en & light_below;
        end
      end else begin
        st_next.light_cnt = 4'h0;
      end
    end

    // Proximity: the near/far state gives hysteresis between the thresholds
    if (PROX_IN.valid) begin
      st_next.prox_result = PROX_IN.data;
      flag_set[lpta_pkg::FLAG_PROX_SAT] = prox_en & PROX_IN.saturated;
      flag_set[lpta_pkg::FLAG_SUN] = prox_en & PROX_IN.sunlight;
      st_next.prox_hi_cnt = 3'h0;
      st_next.prox_lo_cnt = 3'h0;
      if (prox_above & ~st_reg.prox_near) begin
        st_next.prox_hi_cnt = st_reg.prox_hi_cnt + 3'h1;
        if (st_reg.prox_hi_cnt + 3'h1 >= prox_need) begin
          st_next.prox_near = 1'b1;
          st_next.prox_hi_cnt = 3'h0;
          flag_set[lpta_pkg::FLAG_PROX_NEAR] = prox_en;
        end
      end
      if (prox_below & st_reg.prox_near) begin
        st_next.prox_lo_cnt = st_reg.prox_lo_cnt + 3'h1;
        if (st_reg.prox_lo_cnt + 3'h1 >= prox_need) begin
          st_next.prox_near = 1'b0;
          st_next.prox_lo_cnt = 3'h0;
          flag_set[lpta_pkg::FLAG_PROX_FAR] = prox_en;
        end
      end
    end

    // Read clears after data was returned; a fresh event in that cycle survives
    st_next.flags = st_reg.flags;
    if (rd_done && idx == lpta_pkg::IDX_FLAG) begin
      st_next.flags = 8'h00;
    end
    st_next.flags = st_next.flags | flag_set;

    // Pin: level of the near state in logic mode, else any enabled flag
    if (prox_mode) begin
      st_next.alert_n = ~st_next.prox_near;
    end else begin
      st_next.alert_n = ~|(st_next.flags & flag_mask);
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_reg <= '{
        ack: 1'b0,
        dat: 32'h00000000,
        light_conf: lpta_pkg::LIGHT_CONF_RST,
        light_upper: lpta_pkg::LIGHT_UPPER_RST,
        light_lower: lpta_pkg::LIGHT_LOWER_RST,
        light_result: 16'h0000,
        prox_conf: lpta_pkg::PROX_CONF_RST,
        prox_upper: lpta_pkg::PROX_UPPER_RST,
        prox_lower: lpta_pkg::PROX_LOWER_RST,
        prox_result: 8'h00,
        flags: 8'h00,
        light_cnt: 4'h0,
        prox_hi_cnt: 3'h0,
        prox_lo_cnt: 3'h0,
        prox_near: 1'b0,
        alert_n: 1'b1,
        timer: 32'h00000000,
        light_tick: 1'b0
      };
    end else begin
      st_reg <= st_next;
    end
  end

  assign WB_ACK_O = st_reg.ack;
  assign WB_DAT_O = st_reg.dat;
  assign LIGHT_TICK = st_reg.light_tick;
  assign ALERT_N = st_reg.alert_n;

  // Checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  sequence s_light_req;
    WB_CYC_I && WB_STB_I && !WB_WE_I && !st_reg.ack && idx == lpta_pkg::IDX_LIGHT_RESULT;
  endsequence

  sequence s_flag_read_quiet;
    rd_done && idx == lpta_pkg::IDX_FLAG && !PROX_IN.valid && !tick_c;
  endsequence

  property p_ack_single;
    st_reg.ack |=> !st_reg.ack;
  endproperty
  a_ack_single: assert property (p_ack_single) else $error("ack held two cycles");

  property p_light_word;
    s_light_req |=> st_reg.ack && st_reg.dat == {16'h0000, $past(st_reg.light_result)};
  endproperty
  a_light_word: assert property (p_light_word) else $error("light word read wrong");

  property p_flag_clear;
    s_flag_read_quiet |=> st_reg.flags == 8'h00 && (prox_mode || st_reg.alert_n);
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flags not cleared by read");

  property p_alert_low;
    !prox_mode && |(st_reg.flags & flag_mask) && $stable(st_reg.prox_conf) && $stable(st_reg.light_conf)
      |-> !ALERT_N;
  endproperty
  a_alert_low: assert property (p_alert_low) else $error("alert not low with flag set");

  property p_logic_mode;
    prox_mode && $stable(st_reg.prox_conf) |-> ALERT_N == !st_reg.prox_near;
  endproperty
  a_logic_mode: assert property (p_logic_mode) else $error("logic mode pin mismatch");

  property p_light_persist;
    tick_c && light_en && light_above && !light_below && st_reg.light_cnt + 4'h1 == light_need
      |=> st_reg.flags[lpta_pkg::FLAG_LIGHT_ABOVE];
  endproperty
  a_light_persist: assert property (p_light_persist) else $error("light above event missed");

  property p_light_restart;
    tick_c && !light_above && !light_below |=> st_reg.light_cnt == 4'h0;
  endproperty
  a_light_restart: assert property (p_light_restart) else $error("light count not restarted");

  property p_prox_need;
    $rose(st_reg.prox_near) |-> $past(st_reg.prox_hi_cnt) + 3'h1 >= $past(prox_need);
  endproperty
  a_prox_need: assert property (p_prox_need) else $error("near reached too early");

  property p_prox_hyst;
    PROX_IN.valid && !prox_above && !prox_below |=> $stable(st_reg.prox_near);
  endproperty
  a_prox_hyst: assert property (p_prox_hyst) else $error("near state moved inside window");

  property p_tick_period;
    st_reg.light_tick |-> $past(st_reg.timer) >= $past(period) - 32'h1;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("tick before period end");

  property p_upper_word;
    take && !WB_WE_I && idx == lpta_pkg::IDX_LIGHT_UPPER
      |=> st_reg.dat == {16'h0000, $past(st_reg.light_upper)};
  endproperty
  a_upper_word: assert property (p_upper_word) else $error("upper threshold read wrong");

  property p_prox_word;
    take && !WB_WE_I && idx == lpta_pkg::IDX_PROX_RESULT
      |=> st_reg.dat == {24'h000000, $past(st_reg.prox_result)};
  endproperty
  a_prox_word: assert property (p_prox_word) else $error("proximity result read wrong");

  property p_thr_write;
    wr && idx == lpta_pkg::IDX_PROX_THR && WB_SEL_I[1:0] == 2'b11
      |=> {16'h0000, st_reg.prox_upper, st_reg.prox_lower} == ($past(WB_DAT_I) & 32'h0000FFFF);
  endproperty
  a_thr_write: assert property (p_thr_write) else $error("proximity thresholds not written");

  // Counting may run with the channel off, but no flag may appear
  property p_light_off;
    tick_c && !light_en && !rd_done
      |=> (st_reg.flags & lpta_pkg::FLAG_LIGHT_MASK) == ($past(st_reg.flags) & lpta_pkg::FLAG_LIGHT_MASK);
  endproperty
  a_light_off: assert property (p_light_off) else $error("light flag set while disabled");

  property p_sat_flags;
    PROX_IN.valid && prox_en && PROX_IN.saturated && PROX_IN.sunlight
      |=> st_reg.flags[lpta_pkg::FLAG_PROX_SAT] && st_reg.flags[lpta_pkg::FLAG_SUN];
  endproperty
  a_sat_flags: assert property (p_sat_flags) else $error("status flags not set");

  property p_near_event;
    PROX_IN.valid && prox_en && prox_above && !st_reg.prox_near && st_reg.prox_hi_cnt + 3'h1 >= prox_need
      |=> st_reg.prox_near && st_reg.flags[lpta_pkg::FLAG_PROX_NEAR];
  endproperty
  a_near_event: assert property (p_near_event) else $error("near event missed");

  property p_far_event;
    PROX_IN.valid && prox_en && prox_below && st_reg.prox_near && st_reg.prox_lo_cnt + 3'h1 >= prox_need
      |=> !st_reg.prox_near && st_reg.flags[lpta_pkg::FLAG_PROX_FAR];
  endproperty
  a_far_event: assert property (p_far_event) else $error("far event missed");

endmodule // lpta_top
`default_nettype wire

//--- testbench/lpta_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module lpta_host_model (
  input wire logic clk,
  input wire logic wb_ack,
  input wire logic [31:0] wb_rdat,
  output logic wb_cyc,
  output logic wb_stb,
  output logic wb_we,
  output logic [7:0] wb_adr,
  output logic [3:0] wb_sel,
  output logic [31:0] wb_wdat
);
  initial begin
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_wdat = 32'h0000_0000;
  end

  // One classic cycle; the caller's byte selects decide which bytes of a register move
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                      input logic [31:0] wdat, output logic [31:0] rdat);
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= sel;
    wb_wdat <= wdat;
    // Ack and data taken at the rising edge; the slave updates both by non-blocking assignment
    do @(posedge clk); while (wb_ack !== 1'b1);
    rdat = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    // Released address, data and select lines never keep the old value; wb_we keeps it
    wb_adr <= ~adr;
    wb_wdat <= ~wdat;
    wb_sel <= ~sel;
  endtask
endmodule // lpta_host_model
`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int unsigned BASE = 16;
  logic clk;
  logic rst_n;
  logic wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_wdat, wb_rdat;
  logic [15:0] light_data;
  logic light_tick;
  logic alert_n;
  lpta_pkg::lpta_prox_in_s prox_in;
  int fails = 0;
  int checked = 0;

  lpta_top #(.LIGHT_BASE_CYCLES(BASE)) dut (
    .CLK(clk), .RST_N(rst_n), .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb), .WB_WE_I(wb_we),
    .WB_ADR_I(wb_adr), .WB_SEL_I(wb_sel), .WB_DAT_I(wb_wdat), .WB_DAT_O(wb_rdat),
    .WB_ACK_O(wb_ack), .LIGHT_DATA(light_data), .LIGHT_TICK(light_tick),
    .PROX_IN(prox_in), .ALERT_N(alert_n));

  lpta_host_model host (
    .clk(clk), .wb_ack(wb_ack), .wb_rdat(wb_rdat), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_wdat(wb_wdat));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    host.xfer(1'b1, a, 4'h3, d, dummy);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    host.xfer(1'b0, a, 4'hF, 32'h0000_0000, d);
    check(d, exp);
  endtask

  // Pin read after the edge has settled
  task automatic pin(input logic exp);
    #1;
    check({31'h0, alert_n}, {31'h0, exp});
  endtask

  // One valid proximity sample; the pin is settled when this returns
  task automatic prox(input logic [7:0] d);
    @(posedge clk) prox_in <= {1'b1, 2'b00, d};
    @(posedge clk) prox_in.valid <= 1'b0;
    #1;
  endtask

  task automatic tick(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (light_tick !== 1'b1);
  endtask

  task automatic t_reset();
    rd_chk(8'h00, {24'h0, lpta_pkg::LIGHT_CONF_RST});
    rd_chk(8'h04, {16'h0, lpta_pkg::LIGHT_UPPER_RST});
    rd_chk(8'h08, {16'h0, lpta_pkg::LIGHT_LOWER_RST});
    rd_chk(8'h18, {16'h0, lpta_pkg::PROX_UPPER_RST, lpta_pkg::PROX_LOWER_RST});
    rd_chk(8'h34, 32'h0000_0000);
    rd_chk(8'h38, {16'h0, lpta_pkg::ID_RST});
  endtask

  task automatic t_regs();
    logic [31:0] d;
    wr(8'h04, 32'h0000_1234);
    rd_chk(8'h04, 32'h0000_1234);
    host.xfer(1'b1, 8'h04, 4'h1, 32'h0000_00AB, d);
    rd_chk(8'h04, 32'h0000_12AB);
    wr(8'h08, 32'h0000_0BCD);
    rd_chk(8'h08, 32'h0000_0BCD);
    wr(8'h18, 32'h0000_5014);
    rd_chk(8'h18, 32'h0000_5014);
    wr(8'h24, 32'h0000_FFFF);
    rd_chk(8'h24, 32'h0000_0032);
    wr(8'hFC, 32'h0000_FFFF);
    rd_chk(8'hFC, 32'h0000_0000);
    wr(8'h08, 32'h0000_0000);
  endtask

  task automatic t_prox();
    wr(8'h0C, 32'h0000_0005);
    prox(8'h5A);
    prox(8'h32);
    prox(8'h5A);
    pin(1'b1);
    prox(8'h5A);
    pin(1'b0);
    rd_chk(8'h20, 32'h0000_005A);
    rd_chk(8'h34, 32'h0000_0200);
    rd_chk(8'h34, 32'h0000_0000);
    pin(1'b1);
    prox(8'h32);
    prox(8'h5A);
    prox(8'h5A);
    prox(8'h32);
    pin(1'b1);
    prox(8'h0A);
    prox(8'h0A);
    pin(1'b0);
    rd_chk(8'h34, 32'h0000_0100);
    rd_chk(8'h34, 32'h0000_0000);
    // Saturation and sunlight ride on a sample inside the window
    @(posedge clk) prox_in <= {1'b1, 2'b11, 8'h32};
    @(posedge clk) prox_in.valid <= 1'b0;
    pin(1'b0);
    rd_chk(8'h34, 32'h0000_C000);
  endtask

  task automatic t_logic();
    wr(8'h0C, 32'h0000_000C);
    prox(8'h5A);
    pin(1'b0);
    rd_chk(8'h34, 32'h0000_0200);
    rd_chk(8'h34, 32'h0000_0000);
    pin(1'b0);
    prox(8'h0A);
    pin(1'b1);
    rd_chk(8'h34, 32'h0000_0100);
    wr(8'h0C, 32'h0000_0000);
  endtask

  task automatic t_light();
    int n;
    wr(8'h04, 32'h0000_0064);
    wr(8'h08, 32'h0000_000A);
    wr(8'h00, 32'h0000_0046);
    tick(n);
    @(posedge clk) light_data <= 16'h1234;
    tick(n);
    pin(1'b1);
    tick(n);
    check(n, BASE << 1);
    pin(1'b0);
    rd_chk(8'h34, 32'h0000_1000);
    rd_chk(8'h24, 32'h0000_1234);
    @(posedge clk) light_data <= 16'h0032;
    tick(n);
    @(posedge clk) light_data <= 16'h0005;
    tick(n);
    pin(1'b1);
    tick(n);
    pin(1'b0);
    rd_chk(8'h34, 32'h0000_2000);
    // Longest and third integration steps; first tick after a change may be short
    wr(8'h00, 32'h0000_00C0);
    tick(n);
    tick(n);
    check(n, BASE << 3);
    wr(8'h00, 32'h0000_0080);
    tick(n);
    tick(n);
    check(n, BASE << 2);
  endtask

  initial begin
    rst_n = 1'b0;
    light_data = 16'h0032;
    prox_in = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_prox();
    t_logic();
    t_light();
    close_out();
  end

  // Whole run needs under a thousand cycles; this is far beyond it
  initial begin
    #200000;
    fails++;
    close_out();
  end
endmodule // tb_top
`default_nettype wire
